// [core/sipol_latch.sv]
// Serial-in parallel-out latch with storage register and tri-state outputs
`timescale 1ns/1ps
module sipol_latch
  import sipol_pkg::*;
(
  input  wire logic        sys_clk,   // 250 MHz system clock
  input  wire logic        arst_n,    // Asynchronous reset, active low
  input  wire sipol_pins_t pinsIn,    // Raw host pins, asynchronous
  output sipol_par_t       parOut,    // Parallel outputs with enables
  output logic             serialOut  // Last shift stage
);

  // Two-stage synchronisers, first stage read only by the second
  sipol_pins_t syncA_reg;   // First stage
  sipol_pins_t syncB_reg;   // Second stage, safe to use
  sipol_pins_t prevB_reg;   // Previous safe sample, for edge finding

  // Register stages
  logic [SIPOL_WIDTH-1:0] shift_reg;  // Shift register
  logic [SIPOL_WIDTH-1:0] shift_next; // Next shift value
  logic [SIPOL_WIDTH-1:0] store_reg;  // Storage register

  // Edge strobes, one cycle each
  logic shiftEdge; // Rising shift clock
  logic storeEdge; // Rising storage clock

  // Synchronise pins into the system domain
  // Reset to idle pin levels, so no false drive or clear follows reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      syncA_reg <= SIPOL_PINS_IDLE;
      syncB_reg <= SIPOL_PINS_IDLE;
    end else begin
      syncA_reg <= pinsIn;
      syncB_reg <= syncA_reg;
    end
  end

  // Hold previous synchronised sample for edge detection
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prevB_reg <= SIPOL_PINS_IDLE;
    end else begin
      prevB_reg <= syncB_reg;
    end
  end

  // Rising edge of a synchronised level against its previous sample
  function automatic logic riseOf(input logic curLvl, input logic prevLvl);
    return curLvl & ~prevLvl;
  endfunction

  // Rising edges of the two host clocks
  assign shiftEdge = riseOf(syncB_reg.shiftClock, prevB_reg.shiftClock);
  assign storeEdge = riseOf(syncB_reg.storeClock, prevB_reg.storeClock);

  // Next shift value: clear dominates, then shift
  always_comb begin
    shift_next = shift_reg;
    if (!syncB_reg.shiftClearN) begin
      // Clear held regardless of data and clock
      shift_next = '0;
    end else if (shiftEdge) begin
      // Stage 0 takes input, the rest move up one
      shift_next = {shift_reg[SIPOL_WIDTH-2:0], syncB_reg.serialIn};
    end
  end

  // Shift register update; reset value is arbitrary, the part itself has none
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg <= SIPOL_RESET_VAL;
    end else begin
      shift_reg <= shift_next;
    end
  end

  // Storage register samples the pre-shift contents, so simultaneous edges
  // capture the old value while the shift lands in the same cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      store_reg <= SIPOL_RESET_VAL;
    end else if (storeEdge) begin
      store_reg <= shift_reg;
    end
  end

  // Parallel pins: enable only gates drive, never the stored data
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      parOut.level <= '0;
      parOut.oeN   <= '1; // High impedance out of reset
    end else begin
      parOut.level <= store_reg;
      parOut.oeN   <= {SIPOL_WIDTH{syncB_reg.outEnableN}};
    end
  end

  // Serial output follows the last stage, independent of enable
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      serialOut <= 1'b0;
    end else begin
      serialOut <= shift_next[SIPOL_LAST_POS];
    end
  end

  // Clear low empties the shift register next cycle
  property p_clear;
    @(posedge sys_clk) disable iff (!arst_n)
      !syncB_reg.shiftClearN |=> (shift_reg == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("shift clear did not zero");

  // Clear dominates a shift edge
  property p_clear_hold;
    @(posedge sys_clk) disable iff (!arst_n)
      (!syncB_reg.shiftClearN && shiftEdge) |=> (shift_reg == '0);
  endproperty
  a_clear_hold: assert property (p_clear_hold) else $error("clear lost to shift");

  // Shift edge moves the data up one place
  property p_shift;
    @(posedge sys_clk) disable iff (!arst_n)
      (shiftEdge && syncB_reg.shiftClearN) |=>
        (shift_reg == {$past(shift_reg[SIPOL_WIDTH-2:0]), $past(syncB_reg.serialIn)});
  endproperty
  a_shift: assert property (p_shift) else $error("shift wrong");

  // Store edge copies the shift register
  property p_store;
    @(posedge sys_clk) disable iff (!arst_n)
      storeEdge |=> (store_reg == $past(shift_reg));
  endproperty
  a_store: assert property (p_store) else $error("store copy wrong");

  // Both edges together: storage gets the pre-shift contents
  property p_both;
    @(posedge sys_clk) disable iff (!arst_n)
      (storeEdge && shiftEdge && syncB_reg.shiftClearN) |=>
        (store_reg == $past(shift_reg)) &&
        (shift_reg == {$past(shift_reg[SIPOL_WIDTH-2:0]), $past(syncB_reg.serialIn)});
  endproperty
  a_both: assert property (p_both) else $error("simultaneous edge order wrong");

  // No store edge: storage stays still even while shifting
  property p_hold;
    @(posedge sys_clk) disable iff (!arst_n)
      !storeEdge |=> $stable(store_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("storage changed without edge");

  // Disabled outputs are high impedance
  property p_hiz;
    @(posedge sys_clk) disable iff (!arst_n)
      syncB_reg.outEnableN |=> (parOut.oeN == '1);
  endproperty
  a_hiz: assert property (p_hiz) else $error("outputs driven while disabled");

  // Enable toggling leaves stored data untouched
  property p_pwm;
    @(posedge sys_clk) disable iff (!arst_n)
      ($changed(syncB_reg.outEnableN) && !storeEdge) |=> $stable(store_reg);
  endproperty
  a_pwm: assert property (p_pwm) else $error("enable disturbed data");

  // Serial output tracks the last stage
  property p_serial;
    @(posedge sys_clk) disable iff (!arst_n)
      ##1 (serialOut == shift_reg[SIPOL_LAST_POS]);
  endproperty
  a_serial: assert property (p_serial) else $error("serial out mismatch");

  // Serial output moves only on a shift edge or a clear
  property p_serial_still;
    @(posedge sys_clk) disable iff (!arst_n)
      (syncB_reg.shiftClearN && !shiftEdge) |=> $stable(serialOut);
  endproperty
  a_serial_still: assert property (p_serial_still) else $error("serial out moved idle");

  // Clear held low empties the cascade output as well
  property p_clear_serial;
    @(posedge sys_clk) disable iff (!arst_n)
      !syncB_reg.shiftClearN |=> (serialOut == 1'b0);
  endproperty
  a_clear_serial: assert property (p_clear_serial) else $error("serial out not cleared");

  // Enabled outputs drive on every bit
  property p_drive;
    @(posedge sys_clk) disable iff (!arst_n)
      !syncB_reg.outEnableN |=> (parOut.oeN == '0);
  endproperty
  a_drive: assert property (p_drive) else $error("outputs not driven while enabled");

  // One enable for all eight pins, never split
  property p_oe_same;
    @(posedge sys_clk) disable iff (!arst_n)
      (parOut.oeN == '0) || (parOut.oeN == '1);
  endproperty
  a_oe_same: assert property (p_oe_same) else $error("output enables split");

  // Pin levels always show the stored data, whatever the enable does
  property p_level;
    @(posedge sys_clk) disable iff (!arst_n)
      1'b1 |=> (parOut.level == $past(store_reg));
  endproperty
  a_level: assert property (p_level) else $error("pin level not stored data");

  // No store edge: the pin levels stay put too
  property p_level_hold;
    @(posedge sys_clk) disable iff (!arst_n)
      !storeEdge |=> ##1 $stable(parOut.level);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("pin level moved without edge");

  // One host clock rise gives exactly one shift strobe
  property p_shift_one;
    @(posedge sys_clk) disable iff (!arst_n)
      shiftEdge |=> !shiftEdge;
  endproperty
  a_shift_one: assert property (p_shift_one) else $error("shift strobe too long");

  // One storage clock rise gives exactly one store strobe
  property p_store_one;
    @(posedge sys_clk) disable iff (!arst_n)
      storeEdge |=> !storeEdge;
  endproperty
  a_store_one: assert property (p_store_one) else $error("store strobe too long");

endmodule // sipol_latch

// [pkg/sipol_pkg.sv]
// Package for the serial-in parallel-out latch: widths, reset values, carrier types
package sipol_pkg;

  // Stage count of shift and storage registers
  localparam int unsigned SIPOL_WIDTH = 8;

  // Index of the last shift stage, feeding the serial output
  localparam int unsigned SIPOL_LAST_POS = SIPOL_WIDTH - 1;

  // Value loaded at reset: the hardware has no defined power-up value, zero is only a start point
  localparam logic [SIPOL_WIDTH-1:0] SIPOL_RESET_VAL = 8'h00;

  // Sync stages for every pin input
  localparam int unsigned SIPOL_SYNC_STAGES = 2;

  // Pin inputs from the host, carried together
  typedef struct packed {
    logic serialIn;    // Serial data
    logic shiftClock;  // Shift clock
    logic shiftClearN; // Shift clear, active low
    logic storeClock;  // Storage clock
    logic outEnableN;  // Output enable, active low
  } sipol_pins_t;

  // Idle pin levels: clocks low, clear and enable inactive (high)
  localparam sipol_pins_t SIPOL_PINS_IDLE = 5'h05;

  // Parallel output pins: level plus enable (enable low means driving)
  typedef struct packed {
    logic [SIPOL_WIDTH-1:0] level; // Driven level
    logic [SIPOL_WIDTH-1:0] oeN;   // Low while driving, high for high impedance
  } sipol_par_t;

endpackage : sipol_pkg

// [verification/sipol_host_model.sv]
// Host model driving the latch pins as plain general-purpose outputs
`timescale 1ns/1ps
module sipol_host_model
  import sipol_pkg::*;
(
  input  wire logic   sysClk, // Pins change on its falling edge
  output sipol_pins_t pins    // Levels toward the latch
);
  // Half of the 48 ns link period, in 4 ns cycles
  localparam int HALF = 6;
  // Outputs off, clear idle, clocks parked low between frames
  initial pins = SIPOL_PINS_IDLE;
  // Wait falling edges
  task automatic hold(input int n);
    repeat (n) @(negedge sysClk);
  endtask
  // One shift period; a store edge may share the same rising edge
  task automatic clockBit(input logic b, input logic st);
    pins.serialIn = b;
    hold(HALF);
    pins.shiftClock = 1'b1;
    pins.storeClock = st;
    hold(HALF);
    pins.shiftClock = 1'b0;
    pins.storeClock = 1'b0;
    // Data not held past the edge, so a late sample would show
    pins.serialIn = ~b;
  endtask
  // Storage strobe after loading, clear then strobe at init
  task automatic pulseStore;
    pins.storeClock = 1'b1;
    hold(HALF);
    pins.storeClock = 1'b0;
    hold(HALF);
  endtask
endmodule // sipol_host_model

// [verification/sipol_latch_tb_top.sv]
// Self-checking bench for the serial-in parallel-out latch
`timescale 1ns/1ps
module sipol_latch_tb_top;
  import sipol_pkg::*;
  logic        sysClk = 1'b0; // 250 MHz clock
  logic        arstN  = 1'b0; // Reset, active low
  sipol_pins_t pins;          // Host pins
  sipol_par_t  parOut;        // Parallel outputs
  logic        serialOut;     // Cascade output
  logic [7:0]  shiftM;        // Reference shift stages
  logic [7:0]  storeM;        // Reference storage stages
  logic [7:0]  lfsr = 8'h05;  // Random source
  int          nMismatch = 0;
  int          cmpCount = 0;
  // Clock
  initial forever #2 sysClk = ~sysClk;
  sipol_host_model host (.sysClk(sysClk), .pins(pins));
  sipol_latch uut (.sys_clk(sysClk), .arst_n(arstN), .pinsIn(pins), .parOut(parOut),
    .serialOut(serialOut));
  // Next random value
  function automatic logic [7:0] lfsrStep(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Compare a byte
  task automatic cmpVec(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Compare the cascade bit
  task automatic cmpBit(input logic got, input logic exp);
    cmpVec({7'h00, got}, {7'h00, exp});
  endtask
  // Enables and stored data, which must survive enable changes
  task automatic checkOut(input logic oeN);
    cmpVec(parOut.oeN, {8{oeN}});
    cmpVec(parOut.level, storeM);
  endtask
  // One shift, optionally with a store on the same edge
  task automatic shiftBit(input logic b, input logic st);
    host.clockBit(b, st);
    if (st) storeM = shiftM;
    if (pins.shiftClearN) shiftM = {shiftM[6:0], b};
    host.hold(8);
    cmpBit(serialOut, shiftM[7]);
  endtask
  // Storage strobe
  task automatic store;
    host.pulseStore();
    storeM = shiftM;
    host.hold(8);
  endtask
  // Verdict
  task automatic closeOut;
    $display("compares %0d mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Sequence: init, random frames with enable toggling, clear
  initial begin
    repeat (2) @(negedge sysClk);
    arstN = 1'b1;
    host.pins.shiftClearN = 1'b0;
    shiftM = 8'h00;
    shiftBit(1'b1, 1'b0);
    store();
    checkOut(1'b1);
    host.pins.shiftClearN = 1'b1;
    $display("test init done");
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 8; i++) begin
        lfsr = lfsrStep(lfsr);
        host.pins.outEnableN = lfsr[1];
        shiftBit(lfsr[0], r == 3 && i == 5);
        checkOut(lfsr[1]);
      end
      store();
      checkOut(lfsr[1]);
      $display("test frame %0d done", r);
    end
    host.pins.shiftClearN = 1'b0;
    host.hold(8);
    shiftM = 8'h00;
    cmpBit(serialOut, 1'b0);
    store();
    checkOut(lfsr[1]);
    $display("test clear done");
    closeOut();
  end
endmodule // sipol_latch_tb_top
